//--- core/bsw_pkg.sv
/*
  constants, types and register map of the stopwatch block.
  assumes a single 100 MHz clock and a 256 Hz tick pulse from outside.
*/
package bsw_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] ADDR_PRIO  = 16'hff20; // priority levels
  localparam logic [15:0] ADDR_EN    = 16'hff22; // interrupt enables
  localparam logic [15:0] ADDR_FLAG  = 16'hff24; // interrupt factor flags
  localparam logic [15:0] ADDR_CTRL  = 16'hff42; // stopwatch control
  localparam logic [15:0] ADDR_DATA  = 16'hff43; // count data
  // ==========================================================
  // field positions
  localparam int BIT_RUN    = 0; // run/stop in control
  localparam int BIT_CLR    = 1; // clear command in control
  localparam int BIT_PRIO   = 2; // low bit of priority field
  localparam int BIT_SECOND = 4; // one second source
  localparam int BIT_TENTH  = 5; // tenth source
  localparam int BIT_HUND   = 6; // hundredth source
  localparam logic [7:0] SRC_MASK = 8'h70; // the three stopwatch bits
  // ==========================================================
  // reset values and digit limits
  localparam logic [7:0] RST_BYTE  = 8'h00; // every register after reset
  localparam logic [3:0] DIGIT_MAX = 4'h9;  // last bcd value
  // ==========================================================
  // fixed vector addresses
  localparam logic [23:0] VEC_HUND   = 24'h000016; // 100 Hz
  localparam logic [23:0] VEC_TENTH  = 24'h000018; // 10 Hz
  localparam logic [23:0] VEC_SECOND = 24'h00001a; // 1 Hz
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PH_TWO   = 2'b00, // interval of two ticks
    PH_THREE = 2'b01  // interval of three ticks
  } bsw_phase_t;

  typedef struct packed {
    logic [3:0] tenths;    // tenths digit
    logic [3:0] hundredths; // hundredths digit
  } bsw_count_t;

  typedef struct packed {
    logic        wr;   // write strobe
    logic        rd;   // read strobe
    logic [15:0] addr; // byte address
    logic [7:0]  wdata; // write data
  } bsw_bus_t;
endpackage

//--- core/bsw_bcd_digit.sv
/*
  one bcd digit with wrap pulse.
  assumes the caller gives one-cycle advance and clear pulses.
*/
`timescale 1ns/1ps
module bsw_bcd_digit (
  input  wire logic       clk,   // system clock
  input  wire logic       rst,   // sync reset, active high
  input  wire logic       clr,   // clear to zero
  input  wire logic       adv,   // advance by one
  output logic [3:0]      digit, // current value
  output logic            wrap   // pulse when 9 rolls to 0
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [3:0] val;  // digit value
    logic       wrap; // wrap pulse
  } bsw_digit_st_t;

  bsw_digit_st_t s_q; // registered state
  bsw_digit_st_t s_d; // next state

  // next value: wrap from nine back to zero
  always_comb
  begin
    s_d = s_q;
    s_d.wrap = 1'b0;
    if (clr)
    begin
      s_d.val = 4'h0;
    end
    else if (adv)
    begin
      if (s_q.val >= bsw_pkg::DIGIT_MAX)
      begin
        s_d.val  = 4'h0;
        s_d.wrap = 1'b1;
      end
      else
      begin
        s_d.val = s_q.val + 4'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign digit = s_q.val;
  assign wrap  = s_q.wrap;

  a_digit_wrap: assert property (@(posedge clk) disable iff (rst)
    (adv && !clr && s_q.val == 4'h9) |=> (s_q.val == 4'h0 && s_q.wrap))
    else $error("digit did not wrap from nine");
endmodule

//--- core/bsw_stopwatch.sv
/*
  stopwatch timer: run control, 100 Hz divider, two bcd digits,
  factor flags, enables, priority and interrupt request.
  assumes tick_256 is a synchronous one-cycle pulse marking the
  falling edge of the 256 Hz signal, and cpu_level comes from the core.
*/
`timescale 1ns/1ps
module bsw_stopwatch (
  input  wire logic        clk,       // 100 MHz system clock
  input  wire logic        rst,       // sync reset, active high
  input  wire logic        tick_256,  // 256 Hz falling edge pulse
  input  wire logic [15:0] addr,      // register address
  input  wire logic [7:0]  wdata,     // write data
  input  wire logic        wr,        // write strobe
  input  wire logic        rd,        // read strobe
  input  wire logic [1:0]  cpu_level, // current cpu interrupt level
  output logic [7:0]       rdata,     // read data, cycle after rd
  output logic             irq,       // interrupt request level
  output logic [1:0]       irq_level, // priority of the request
  output logic [23:0]      irq_vector // vector of highest enabled pending source
);
  // ==========================================================
  // state record
  typedef struct packed {
    logic                 run_req;  // last run value written
    logic                 running;  // run state actually applied
    bsw_pkg::bsw_phase_t  phase;    // divider interval kind
    logic [1:0]           tcnt;     // ticks in current interval
    logic                 hund_p;   // 100 Hz pulse into digits
    logic [1:0]           prio;     // priority field
    logic [2:0]           en;       // enables: hund, tenth, second
    logic [2:0]           flag;     // flags: hund, tenth, second
    logic [7:0]           rdata;    // read data
    logic                 irq;      // request
    logic [1:0]           irq_lvl;  // request level
    logic [23:0]          vec;      // request vector
  } bsw_state_t;

  bsw_state_t       s_q;     // registered state
  bsw_state_t       s_d;     // next state
  bsw_pkg::bsw_bus_t bus;    // bundled bus request
  bsw_pkg::bsw_count_t cnt;  // digits as read
  logic             clr_cmd; // clear written this cycle
  logic             tenth_p; // wrap of hundredths
  logic             sec_p;   // wrap of tenths
  logic             sw_run_bit; // run bit as read back

  assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  // ==========================================================
  // helpers
  // byte address match for one register
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  // place the three source bits into their register lanes
  function automatic logic [7:0] lanes(input logic [2:0] v);
    lanes = {1'b0, v, 4'h0};
  endfunction

  // clear command: write of one to bit 1 of control
  assign clr_cmd = bus.wr && hit(bus.addr, bsw_pkg::ADDR_CTRL)
                   && bus.wdata[bsw_pkg::BIT_CLR];
  // run bit reads 1 until the stop actually lands
  assign sw_run_bit = s_q.run_req | s_q.running;

  // ==========================================================
  // digits: hundredths feeds tenths
  bsw_bcd_digit u_hund (
    .clk   (clk),
    .rst   (rst),
    .clr   (clr_cmd),
    .adv   (s_q.hund_p),
    .digit (cnt.hundredths),
    .wrap  (tenth_p)
  );

  bsw_bcd_digit u_tenth (
    .clk   (clk),
    .rst   (rst),
    .clr   (clr_cmd),
    .adv   (tenth_p),
    .digit (cnt.tenths),
    .wrap  (sec_p)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    logic [2:0] src;    // source pulses this cycle
    logic [2:0] clrm;   // write-one-to-clear mask
    logic [2:0] act;    // enabled pending sources
    logic       adv;    // divider interval done
    src  = 3'b000;
    clrm = 3'b000;
    act  = 3'b000;
    adv  = 1'b0;
    s_d  = s_q;
    s_d.hund_p = 1'b0;

    // run changes and counting only on a tick
    if (tick_256)
    begin
      s_d.running = s_q.run_req;
      if (s_q.running)
      begin
        // 2 then 3 ticks, giving about 100 Hz
        adv = (s_q.phase == bsw_pkg::PH_TWO) ? (s_q.tcnt == 2'd1)
                                             : (s_q.tcnt == 2'd2);
        if (adv)
        begin
          s_d.tcnt   = 2'd0;
          s_d.hund_p = 1'b1;
          case (s_q.phase)
            bsw_pkg::PH_TWO:   s_d.phase = bsw_pkg::PH_THREE;
            bsw_pkg::PH_THREE: s_d.phase = bsw_pkg::PH_TWO;
            default:           s_d.phase = bsw_pkg::PH_TWO;
          endcase
        end
        else
        begin
          s_d.tcnt = s_q.tcnt + 2'd1;
        end
      end
    end

    // clear also restarts the divider from zero
    if (clr_cmd)
    begin
      s_d.tcnt   = 2'd0;
      s_d.phase  = bsw_pkg::PH_TWO;
      s_d.hund_p = 1'b0;
    end

    // register writes; data register has no write path
    if (bus.wr)
    begin
      if (hit(bus.addr, bsw_pkg::ADDR_CTRL))
        s_d.run_req = bus.wdata[bsw_pkg::BIT_RUN];
      if (hit(bus.addr, bsw_pkg::ADDR_PRIO))
        s_d.prio = bus.wdata[bsw_pkg::BIT_PRIO +: 2];
      if (hit(bus.addr, bsw_pkg::ADDR_EN))
        s_d.en = bus.wdata[bsw_pkg::BIT_SECOND +: 3];
      if (hit(bus.addr, bsw_pkg::ADDR_FLAG))
        clrm = bus.wdata[bsw_pkg::BIT_SECOND +: 3];
    end

    // flags: set wins over a same-cycle clear
    src = {s_q.hund_p, tenth_p, sec_p};
    s_d.flag = (s_q.flag & ~{clrm[2], clrm[1], clrm[0]}) | src;

    // read mux, answer in the next cycle only
    s_d.rdata = 8'h00;
    if (bus.rd)
    begin
      if (hit(bus.addr, bsw_pkg::ADDR_CTRL))
        s_d.rdata = {7'h00, sw_run_bit};
      else if (hit(bus.addr, bsw_pkg::ADDR_DATA))
        s_d.rdata = cnt;
      else if (hit(bus.addr, bsw_pkg::ADDR_PRIO))
        s_d.rdata = {4'h0, s_q.prio, 2'b00};
      else if (hit(bus.addr, bsw_pkg::ADDR_EN))
        s_d.rdata = lanes(s_q.en);
      else if (hit(bus.addr, bsw_pkg::ADDR_FLAG))
        s_d.rdata = lanes(s_q.flag);
      else
        s_d.rdata = 8'h00;
    end

    // request: flag and enable and priority above cpu level
    act = s_q.flag & s_q.en;
    s_d.irq     = (act != 3'b000) && (s_q.prio > cpu_level);
    s_d.irq_lvl = s_q.prio;
    if (act[2])
      s_d.vec = bsw_pkg::VEC_HUND;
    else if (act[1])
      s_d.vec = bsw_pkg::VEC_TENTH;
    else if (act[0])
      s_d.vec = bsw_pkg::VEC_SECOND;
    else
      s_d.vec = 24'h000000;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rdata      = s_q.rdata;
  assign irq        = s_q.irq;
  assign irq_level  = s_q.irq_lvl;
  assign irq_vector = s_q.vec;

  // ==========================================================
  // checks
  a_data_read: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == 16'hff43) |=> (rdata == $past(cnt)))
    else $error("data read does not show digits");

  a_data_nowrite: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == 16'hff43 && !tick_256 && !s_q.hund_p && !tenth_p)
      |=> (cnt.hundredths == $past(cnt.hundredths)))
    else $error("data write changed count");

  a_clear_zero: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == 16'hff42 && wdata[1]) |=> (cnt == 8'h00))
    else $error("clear did not zero count");

  a_run_hold: assert property (@(posedge clk) disable iff (rst)
    (s_q.running && !tick_256) |=> s_q.running)
    else $error("run state changed off tick");

  a_flag_set: assert property (@(posedge clk) disable iff (rst)
    s_q.hund_p |=> s_q.flag[2])
    else $error("hundredth flag not set");

  a_flag_clear: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == 16'hff24 && wdata[6] && !s_q.hund_p) |=> !s_q.flag[2])
    else $error("hundredth flag not cleared");

  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    irq |-> ($past(s_q.prio) > $past(cpu_level)))
    else $error("request below cpu level");

  a_ctrl_read: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == 16'hff42) |=> (rdata[7:1] == 7'h00))
    else $error("control unused bits not zero");

  a_divider_gap: assert property (@(posedge clk) disable iff (rst)
    (s_q.hund_p) |=> !s_q.hund_p)
    else $error("100 Hz pulse longer than one cycle");

  a_prio_read: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == 16'hff20) |=> (rdata == {4'h0, $past(s_q.prio), 2'b00}))
    else $error("priority read wrong");

  // ==========================================================
  // register and counting checks
  // enables read back in their lanes, bit 7 low
  a_en_read: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == bsw_pkg::ADDR_EN) |=> (rdata == {1'b0, $past(s_q.en), 4'h0}))
    else $error("enable read wrong");

  // flags read back in their lanes, bit 7 low
  a_flag_read: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == bsw_pkg::ADDR_FLAG) |=> (rdata == {1'b0, $past(s_q.flag), 4'h0}))
    else $error("flag read wrong");

  // enable write lands in the next cycle
  a_en_write: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == bsw_pkg::ADDR_EN)
      |=> (s_q.en == $past(wdata[bsw_pkg::BIT_SECOND +: 3])))
    else $error("enable write lost");

  // enables keep their value without a write
  a_en_hold: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == bsw_pkg::ADDR_EN) |=> (s_q.en == $past(s_q.en)))
    else $error("enables changed without write");

  // priority write lands in the next cycle
  a_prio_write: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == bsw_pkg::ADDR_PRIO)
      |=> (s_q.prio == $past(wdata[bsw_pkg::BIT_PRIO +: 2])))
    else $error("priority write lost");

  // priority keeps its value without a write
  a_prio_hold: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == bsw_pkg::ADDR_PRIO) |=> (s_q.prio == $past(s_q.prio)))
    else $error("priority changed without write");

  // run request follows bit 0 of a control write
  a_run_write: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == bsw_pkg::ADDR_CTRL)
      |=> (s_q.run_req == $past(wdata[bsw_pkg::BIT_RUN])))
    else $error("run bit write lost");

  // applied run state copies the request on a tick
  a_run_apply: assert property (@(posedge clk) disable iff (rst)
    tick_256 |=> (s_q.running == $past(s_q.run_req)))
    else $error("run state not applied on tick");

  // stopped counter holds its hundredths digit
  a_stop_freeze: assert property (@(posedge clk) disable iff (rst)
    (!s_q.running && !s_q.hund_p && !clr_cmd) |=> $stable(cnt.hundredths))
    else $error("count moved while stopped");

  // 100 Hz pulse only ever follows a tick
  a_hund_tick: assert property (@(posedge clk) disable iff (rst)
    s_q.hund_p |-> $past(tick_256))
    else $error("100 Hz pulse without tick");

  // each 100 Hz pulse adds one to the hundredths
  a_hund_adv: assert property (@(posedge clk) disable iff (rst)
    (s_q.hund_p && !clr_cmd && cnt.hundredths != bsw_pkg::DIGIT_MAX)
      |=> (cnt.hundredths == $past(cnt.hundredths) + 4'h1))
    else $error("hundredths did not advance");

  // hundredths wrap adds one to the tenths
  a_tenth_adv: assert property (@(posedge clk) disable iff (rst)
    (tenth_p && !clr_cmd && cnt.tenths != bsw_pkg::DIGIT_MAX)
      |=> (cnt.tenths == $past(cnt.tenths) + 4'h1))
    else $error("tenths did not advance");

  // both digits stay inside bcd range
  a_digit_bcd: assert property (@(posedge clk) disable iff (rst)
    (cnt.hundredths <= bsw_pkg::DIGIT_MAX) && (cnt.tenths <= bsw_pkg::DIGIT_MAX))
    else $error("digit out of bcd range");

  // clear restarts the divider at a two-tick interval
  a_clear_restart: assert property (@(posedge clk) disable iff (rst)
    clr_cmd |=> (s_q.tcnt == 2'd0 && s_q.phase == bsw_pkg::PH_TWO))
    else $error("divider not restarted by clear");

  // tenth-rate pulse sets its flag
  a_tenth_flag: assert property (@(posedge clk) disable iff (rst)
    tenth_p |=> s_q.flag[1])
    else $error("tenth flag not set");

  // one-second pulse sets its flag
  a_sec_flag: assert property (@(posedge clk) disable iff (rst)
    sec_p |=> s_q.flag[0])
    else $error("second flag not set");

  // a flag stays up until a one is written to it
  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    (s_q.flag[2] && !(wr && addr == bsw_pkg::ADDR_FLAG && wdata[bsw_pkg::BIT_HUND]))
      |=> s_q.flag[2])
    else $error("hundredth flag dropped");

  // nothing enabled and pending means no request
  a_irq_off: assert property (@(posedge clk) disable iff (rst)
    ((s_q.flag & s_q.en) == 3'b000) |=> !irq)
    else $error("request without enabled flag");

  // enabled pending source above cpu level raises a request
  a_irq_on: assert property (@(posedge clk) disable iff (rst)
    (((s_q.flag & s_q.en) != 3'b000) && (s_q.prio > cpu_level)) |=> irq)
    else $error("request missing");

  // hundredth source wins the vector
  a_vec_hund: assert property (@(posedge clk) disable iff (rst)
    (s_q.flag[2] && s_q.en[2]) |=> (irq_vector == bsw_pkg::VEC_HUND))
    else $error("hundredth vector wrong");
endmodule

//--- verification/bsw_cpu_model.sv
/*
  cpu side model: register bus master, cpu level and 256 Hz tick source.
  assumes the stopwatch samples strobes and ticks on the rising clock edge.
*/
`timescale 1ns/1ps
module bsw_cpu_model (
  input  wire logic       clk,       // system clock
  output logic [15:0]     addr,      // register address
  output logic [7:0]      wdata,     // write data
  output logic            wr,        // write strobe
  output logic            rd,        // read strobe
  output logic [1:0]      cpu_level, // current cpu level
  output logic            tick_256,  // tick fall pulse
  input  wire logic [7:0] rdata      // read data
);
  // ==========================================================
  // idle values at time zero
  initial
  begin
    addr      = 16'h0000;
    wdata     = 8'h00;
    wr        = 1'b0;
    rd        = 1'b0;
    cpu_level = 2'h0;
    tick_256  = 1'b0;
  end
  // ==========================================================
  // bus cycles
  // lines are scrambled after use so stale values never look valid
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  end
  endtask
  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
  begin
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  end
  endtask
  // ==========================================================
  // tick pulses, short spacing keeps long counts cheap
  task automatic ticks(input int n);
  begin
    repeat (n)
    begin
      repeat (3) @(posedge clk);
      tick_256 <= 1'b1;
      @(posedge clk);
      tick_256 <= 1'b0;
    end
    repeat (2) @(posedge clk);
  end
  endtask
  // cpu level change
  task automatic set_level(input logic [1:0] l);
  begin
    @(posedge clk);
    cpu_level <= l;
  end
  endtask
endmodule

//--- verification/tb_bsw_stopwatch.sv
/*
  self-checking bench of the stopwatch block.
  assumes the cpu model drives every input of the block except clk and rst, which the bench drives.
*/
`timescale 1ns/1ps
module tb_bsw_stopwatch;
  logic        clk;        // system clock
  logic        rst;        // sync reset
  logic [15:0] addr;       // bus address
  logic [7:0]  wdata;      // bus write data
  logic        wr;         // write strobe
  logic        rd;         // read strobe
  logic [1:0]  cpu_level;  // cpu level
  logic        tick_256;   // tick pulse
  logic [7:0]  rdata;      // read data
  logic        irq;        // request
  logic [1:0]  irq_level;  // request level
  logic [23:0] irq_vector; // request vector
  logic [7:0]  v;          // last read value
  int          n_mismatch; // mismatches
  int          num_checks; // comparisons
  // ==========================================================
  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // instances
  // cpu side: bus master, level and tick source
  bsw_cpu_model u_cpu (
    .clk       (clk),       // system clock
    .addr      (addr),      // bus address
    .wdata     (wdata),     // bus write data
    .wr        (wr),        // write strobe
    .rd        (rd),        // read strobe
    .cpu_level (cpu_level), // cpu level
    .tick_256  (tick_256),  // tick pulse
    .rdata     (rdata)      // read data
  );
  // block under test
  bsw_stopwatch dut_u (
    .clk        (clk),        // system clock
    .rst        (rst),        // sync reset
    .tick_256   (tick_256),   // tick pulse
    .addr       (addr),       // bus address
    .wdata      (wdata),      // bus write data
    .wr         (wr),         // write strobe
    .rd         (rd),         // read strobe
    .cpu_level  (cpu_level),  // cpu level
    .rdata      (rdata),      // read data
    .irq        (irq),        // request
    .irq_level  (irq_level),  // request level
    .irq_vector (irq_vector)  // request vector
  );
  // ==========================================================
  // helpers
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
  begin
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // masked register read, mask keeps only bits this block owns
  task automatic rdchk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
  begin
    u_cpu.bus_rd(a, v);
    check({16'h0000, v & m}, {16'h0000, e});
  end
  endtask
  // request outputs lag one cycle, so let them settle
  task automatic irqchk(input logic i, input logic [23:0] vec);
  begin
    repeat (3) @(posedge clk);
    #1;
    check({23'h0, irq}, {23'h0, i});
    check(irq_vector, vec);
  end
  endtask
  task automatic close_out();
  begin
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
  begin
    rdchk(bsw_pkg::ADDR_PRIO, 8'hff, 8'h00);
    rdchk(bsw_pkg::ADDR_EN, 8'hff, 8'h00);
    rdchk(bsw_pkg::ADDR_FLAG, 8'hff, 8'h00);
    rdchk(bsw_pkg::ADDR_CTRL, 8'hff, 8'h00);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h00);
    rdchk(16'hff30, 8'hff, 8'h00);
    irqchk(1'b0, 24'h0);
  end
  endtask
  task automatic t_regs();
  begin
    for (int l = 0; l < 4; l++)
    begin
      u_cpu.bus_wr(bsw_pkg::ADDR_PRIO, {4'h0, l[1:0], 2'b00});
      rdchk(bsw_pkg::ADDR_PRIO, 8'h0c, {4'h0, l[1:0], 2'b00});
      check({22'h0, irq_level}, {22'h0, l[1:0]});
    end
    u_cpu.bus_wr(bsw_pkg::ADDR_EN, 8'hff);
    rdchk(bsw_pkg::ADDR_EN, 8'hf0, 8'h70);
    u_cpu.bus_wr(bsw_pkg::ADDR_EN, 8'h00);
    rdchk(bsw_pkg::ADDR_EN, 8'hf0, 8'h00);
    u_cpu.bus_wr(bsw_pkg::ADDR_FLAG, 8'hff);
    rdchk(bsw_pkg::ADDR_FLAG, 8'hf0, 8'h00);
    u_cpu.bus_wr(bsw_pkg::ADDR_DATA, 8'h55);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h00);
  end
  endtask
  // divider gives a count after 2 then 3 running ticks
  task automatic t_count();
  begin
    u_cpu.bus_wr(bsw_pkg::ADDR_CTRL, 8'hfd);
    rdchk(bsw_pkg::ADDR_CTRL, 8'hff, 8'h01);
    u_cpu.ticks(1);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h00);
    u_cpu.ticks(2);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h01);
    rdchk(bsw_pkg::ADDR_FLAG, 8'h70, 8'h40);
    u_cpu.ticks(2);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h01);
    u_cpu.ticks(1);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h02);
    u_cpu.ticks(20);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h10);
    rdchk(bsw_pkg::ADDR_FLAG, 8'h70, 8'h60);
  end
  endtask
  task automatic t_irq();
  begin
    u_cpu.set_level(2'h1);
    u_cpu.bus_wr(bsw_pkg::ADDR_PRIO, 8'h08);
    u_cpu.bus_wr(bsw_pkg::ADDR_EN, 8'h60);
    irqchk(1'b1, bsw_pkg::VEC_HUND);
    u_cpu.bus_wr(bsw_pkg::ADDR_FLAG, 8'h40);
    rdchk(bsw_pkg::ADDR_FLAG, 8'h70, 8'h20);
    irqchk(1'b1, bsw_pkg::VEC_TENTH);
    u_cpu.set_level(2'h2);
    // vector still names the pending source, only the request drops
    irqchk(1'b0, bsw_pkg::VEC_TENTH);
    u_cpu.set_level(2'h1);
    u_cpu.bus_wr(bsw_pkg::ADDR_EN, 8'h00);
    irqchk(1'b0, 24'h0);
    u_cpu.ticks(225);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h00);
    rdchk(bsw_pkg::ADDR_FLAG, 8'h70, 8'h70);
    u_cpu.bus_wr(bsw_pkg::ADDR_FLAG, 8'h60);
    u_cpu.bus_wr(bsw_pkg::ADDR_EN, 8'h10);
    irqchk(1'b1, bsw_pkg::VEC_SECOND);
    u_cpu.bus_wr(bsw_pkg::ADDR_FLAG, 8'h10);
    irqchk(1'b0, 24'h0);
  end
  endtask
  // stop is taken at the next tick, which still counts
  task automatic t_stop();
  begin
    u_cpu.ticks(4);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h01);
    u_cpu.bus_wr(bsw_pkg::ADDR_CTRL, 8'h00);
    rdchk(bsw_pkg::ADDR_CTRL, 8'hff, 8'h01);
    u_cpu.ticks(1);
    rdchk(bsw_pkg::ADDR_CTRL, 8'hff, 8'h00);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h02);
    u_cpu.ticks(6);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h02);
    u_cpu.bus_wr(bsw_pkg::ADDR_CTRL, 8'h02);
    rdchk(bsw_pkg::ADDR_CTRL, 8'hff, 8'h00);
    u_cpu.ticks(5);
    rdchk(bsw_pkg::ADDR_DATA, 8'hff, 8'h00);
  end
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    rst        = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_count();
    t_irq();
    t_stop();
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
endmodule
